// ==== src/lfo_watchdog_timer.sv ====
`timescale 1ns/1ns
// Operation
// - Counter reaching the interval limit raises the system reset request.
// - After reset the watchdog is enabled, counting, longest interval selected.
// - Every system reset enables the watchdog and clears its counter.
// - Timing element is a 16-bit counter with programmable period.
// - While enabled the counter advances once per divided oscillator tick.
// - Oscillator is held running while active; stop requests are ignored.
// - Writing the reload code enables the watchdog and clears the counter.
// - Disable needs first key then second key within 4 clocks.
// - Lock code blocks every later disable until the next system reset.
// - Lock write leaves enable state and counter unchanged, no reload.
// - Disabling stops counting but keeps the counter value.
// - Comparator stays active even while disabled.
// - Timeout equals oscillator period times four to the interval plus three.
// - Write with top bit zero loads the interval; software keeps it zero.
// - Read returns interval in low bits; reads 0x17 after reset.
// - Reload after 2 ticks, interval after 1 clock, disable after 3 ticks.
// - Bit four reads one while active and zero while inactive.
module lfo_watchdog_timer
  import watchdog_pkg::*;
#(
  parameter int COUNT_WIDTH = 16,
  parameter int DIV_SHIFT = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic lfo_tick,
  input wire watchdog_pkg::sfr_access_type sfr,
  input wire logic osc_stop_req,
  output logic [7:0] sfr_rdata,
  output logic watchdog_reset,
  output logic osc_run
);
  import watchdog_pkg::*;

  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};
  localparam logic [2:0] KEY_LOAD = 3'(KEY_WINDOW_CYCLES);

  logic hit_wr;
  logic hit_rd;
  logic enabled;
  logic locked;
  logic [2:0] interval;
  logic [2:0] key_window;
  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH:0] limit;
  logic reload_req;
  logic disable_req;
  logic reload_apply;
  logic disable_apply;
  logic [4:0] limit_shift;

  // Port decode of the single control register
  assign hit_wr = sfr.wr && (sfr.addr == CONTROL_OFFSET);
  assign hit_rd = sfr.rd && (sfr.addr == CONTROL_OFFSET);

  // Reload code; the lock code is deliberately not a reload
  assign reload_req = hit_wr && (sfr.wdata == CMD_RELOAD);
  assign disable_req = hit_wr && (sfr.wdata == CMD_KEY_SECOND) && (key_window != 3'h0)
                       && !locked;

  // First key opens a short window; any later control-register write inside it other than the first key spends it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      key_window <= 3'h0;
    end else if (clk_en) begin
      if (hit_wr && sfr.wdata == CMD_KEY_FIRST) begin
        key_window <= KEY_LOAD;
      end else if (hit_wr) begin
        key_window <= 3'h0;
      end else if (key_window != 3'h0) begin
        key_window <= key_window - 3'h1;
      end
    end
  end

  // Lock is sticky; only the system reset releases it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      locked <= 1'b0;
    end else if (clk_en && hit_wr && sfr.wdata == CMD_LOCK) begin
      locked <= 1'b1;
    end
  end

  // Interval loads one core clock after a mode-zero write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      interval <= INTERVAL_RESET;
    end else if (clk_en && hit_wr && !sfr.wdata[MODE_BIT]) begin
      interval <= sfr.wdata[INTERVAL_MSB:0];
    end
  end

  // Commands wait for the tick domain before touching the counter
  wdt_cmd_sync #(
    .STAGES(RELOAD_STAGES)
  ) u_reload_sync (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(lfo_tick),
    .req(reload_req),
    .apply(reload_apply)
  );

  wdt_cmd_sync #(
    .STAGES(DISABLE_STAGES)
  ) u_disable_sync (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .tick(lfo_tick),
    .req(disable_req),
    .apply(disable_apply)
  );

  // Enable state; reload wins when both land together, lock vetoes late disables
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enabled <= 1'b1;
    end else if (clk_en) begin
      if (reload_apply) begin
        enabled <= 1'b1;
      end else if (disable_apply && !locked) begin
        enabled <= 1'b0;
      end
    end
  end

  // Counter saturates instead of wrapping so an overflow is never missed
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clk_en) begin
      if (reload_apply) begin
        count <= '0;
      end else if (enabled && lfo_tick && count != COUNT_MAX) begin
        count <= count + 1'b1;
      end
    end
  end

  // Ticks are already divided by 2^DIV_SHIFT, so the exponent shrinks by that much
  assign limit_shift = 5'(2 * (32'(interval) + INTERVAL_EXP_BIAS) - DIV_SHIFT);
  assign limit = (COUNT_WIDTH + 1)'(1) << limit_shift;

  // Comparator ignores the enable; the surrounding reset clears this flop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchdog_reset <= 1'b0;
    end else if (clk_en) begin
      watchdog_reset <= ({1'b0, count} >= limit);
    end
  end

  // Oscillator may stop only when the watchdog is inactive
  assign osc_run = enabled | ~osc_stop_req;

  // Read data: active flag and interval, other bits zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en) begin
      sfr_rdata <= hit_rd ? {3'h0, enabled, 1'b0, interval} : 8'h00;
    end
  end

  // Guards on the command, counter and read paths
  property p_interval_load;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_wr && !sfr.wdata[MODE_BIT]) |=> (interval == $past(sfr.wdata[2:0]));
  endproperty
  a_interval_load: assert property (p_interval_load)
    else $error("interval not loaded");

  property p_interval_hold;
    @(posedge mclk) disable iff (reset)
    !(clk_en && hit_wr && !sfr.wdata[MODE_BIT]) |=> $stable(interval);
  endproperty
  a_interval_hold: assert property (p_interval_hold)
    else $error("interval changed without a write");

  property p_reset_defaults;
    @(posedge mclk) disable iff (reset)
    $fell(reset) |-> (enabled && count == '0 && interval == INTERVAL_RESET && !locked);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("state after reset wrong");

  property p_reset_on_limit;
    @(posedge mclk) disable iff (reset)
    (clk_en && {1'b0, count} >= limit) |=> watchdog_reset;
  endproperty
  a_reset_on_limit: assert property (p_reset_on_limit)
    else $error("no reset at limit");

  property p_no_early_reset;
    @(posedge mclk) disable iff (reset)
    (clk_en && {1'b0, count} < limit) |=> !watchdog_reset;
  endproperty
  a_no_early_reset: assert property (p_no_early_reset)
    else $error("reset below limit");

  property p_reset_while_off;
    @(posedge mclk) disable iff (reset)
    (clk_en && !enabled && {1'b0, count} >= limit) |=> watchdog_reset;
  endproperty
  a_reset_while_off: assert property (p_reset_while_off)
    else $error("comparator idle while disabled");

  property p_lock_sticky;
    @(posedge mclk) disable iff (reset)
    locked |=> locked [*2];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock released");

  property p_locked_stays_on;
    @(posedge mclk) disable iff (reset)
    (locked && enabled) |=> enabled;
  endproperty
  a_locked_stays_on: assert property (p_locked_stays_on)
    else $error("disabled while locked");

  property p_lock_no_reload;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_wr && sfr.wdata == CMD_LOCK && !lfo_tick)
      |=> (enabled == $past(enabled) && count == $past(count));
  endproperty
  a_lock_no_reload: assert property (p_lock_no_reload)
    else $error("lock write touched the watchdog");

  property p_key_opens;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_wr && sfr.wdata == CMD_KEY_FIRST) |=> (key_window == KEY_LOAD);
  endproperty
  a_key_opens: assert property (p_key_opens)
    else $error("key window not opened");

  property p_key_spent;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_wr && sfr.wdata != CMD_KEY_FIRST) |=> (key_window == 3'h0);
  endproperty
  a_key_spent: assert property (p_key_spent)
    else $error("key window left open");

  property p_disable_needs_key;
    @(posedge mclk) disable iff (reset)
    (enabled && !(clk_en && disable_apply)) |=> enabled;
  endproperty
  a_disable_needs_key: assert property (p_disable_needs_key)
    else $error("disabled without a key");

  property p_disable_applies;
    @(posedge mclk) disable iff (reset)
    (clk_en && disable_apply && !reload_apply && !locked) |=> !enabled;
  endproperty
  a_disable_applies: assert property (p_disable_applies)
    else $error("disable not applied");

  property p_tick_count;
    @(posedge mclk) disable iff (reset)
    (clk_en && enabled && lfo_tick && !reload_apply && count != COUNT_MAX)
      |=> (count == $past(count) + 1'b1);
  endproperty
  a_tick_count: assert property (p_tick_count)
    else $error("counter missed a tick");

  property p_disabled_holds;
    @(posedge mclk) disable iff (reset)
    (!enabled && !reload_apply) |=> $stable(count);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds)
    else $error("counter moved while off");

  property p_reload_clears;
    @(posedge mclk) disable iff (reset)
    (clk_en && reload_apply) |=> (count == '0 && enabled);
  endproperty
  a_reload_clears: assert property (p_reload_clears)
    else $error("reload ineffective");

  property p_osc_forced;
    @(posedge mclk) disable iff (reset)
    enabled |-> osc_run;
  endproperty
  a_osc_forced: assert property (p_osc_forced)
    else $error("oscillator stopped while active");

  property p_status_read;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_rd) |=> (sfr_rdata[ACTIVE_BIT] == $past(enabled));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("active bit wrong");

  property p_read_interval;
    @(posedge mclk) disable iff (reset)
    (clk_en && hit_rd) |=> (sfr_rdata[INTERVAL_MSB:0] == $past(interval));
  endproperty
  a_read_interval: assert property (p_read_interval)
    else $error("interval field wrong");

  property p_read_idle;
    @(posedge mclk) disable iff (reset)
    (clk_en && !hit_rd) |=> (sfr_rdata == 8'h00);
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data without a read");

  property p_reload_delay;
    @(posedge mclk) disable iff (reset)
    (clk_en && reload_req) |-> !reload_apply;
  endproperty
  a_reload_delay: assert property (p_reload_delay)
    else $error("reload applied too early");
endmodule // lfo_watchdog_timer

// ==== src/watchdog_pkg.sv ====
package watchdog_pkg;
  // Register map and command codes
  localparam logic [7:0] CONTROL_OFFSET = 8'h97;
  localparam logic [7:0] CONTROL_RESET = 8'h17;
  localparam logic [7:0] CMD_RELOAD = 8'hA5;
  localparam logic [7:0] CMD_KEY_FIRST = 8'hDE;
  localparam logic [7:0] CMD_KEY_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCK = 8'hFF;
  // Field positions
  localparam int MODE_BIT = 7;
  localparam int ACTIVE_BIT = 4;
  localparam int INTERVAL_MSB = 2;
  localparam logic [2:0] INTERVAL_RESET = 3'h7;
  localparam int INTERVAL_EXP_BIAS = 3;
  // Timing: key window and interval delay in core clocks, command apply delays in divided ticks
  localparam int KEY_WINDOW_CYCLES = 4;
  localparam int RELOAD_STAGES = 2;
  localparam int DISABLE_STAGES = 3;
  localparam int INTERVAL_DELAY_CYCLES = 1;
  localparam int CORE_PERIOD_NS = 8;

  // One access on the special-function-register port
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_access_type;
endpackage

// ==== src/wdt_cmd_sync.sv ====
`timescale 1ns/1ns
// Carries a one-cycle core command onto the divided tick and applies it on the STAGES-th tick
module wdt_cmd_sync #(
  parameter int STAGES = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic req,
  output logic apply
);
  logic pend;
  logic [STAGES-2:0] stage;

  // Set wins over the tick that would move the old request on
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend <= 1'b0;
    end else if (clk_en) begin
      pend <= req | (pend & ~tick);
    end
  end

  // Tick-enabled stages; the counter only ever sees settled stage outputs
  genvar i;
  generate
    for (i = 0; i < STAGES - 1; i++) begin : g_stage
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          stage[i] <= 1'b0;
        end else if (clk_en && tick) begin
          stage[i] <= (i == 0) ? pend : stage[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign apply = tick & stage[STAGES-2];
endmodule // wdt_cmd_sync

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import watchdog_pkg::*;
  // Core cycles per divided oscillator tick; long enough for two key writes
  localparam int TP = 8;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic lfo_tick = 1'b0;
  sfr_access_type sfr = '0;
  logic osc_stop_req = 1'b1;
  logic [7:0] sfr_rdata;
  logic watchdog_reset;
  logic osc_run;
  int fails = 0;
  int num_checks = 0;
  int tick_cnt = 0;
  int cycles = 0;

  lfo_watchdog_timer #(.COUNT_WIDTH(16), .DIV_SHIFT(5)) u_lfo_watchdog_timer (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .lfo_tick(lfo_tick),
    .sfr(sfr),
    .osc_stop_req(osc_stop_req),
    .sfr_rdata(sfr_rdata),
    .watchdog_reset(watchdog_reset),
    .osc_run(osc_run)
  );

  // Core clock
  always #(CORE_PERIOD_NS / 2) mclk = ~mclk;

  // Divided tick, free running so commands land at every phase of it
  always @(negedge mclk) begin
    tick_cnt <= (tick_cnt == TP - 1) ? 0 : tick_cnt + 1;
    lfo_tick <= (tick_cnt == TP - 2);
  end

  // Hang guard, well above the roughly 760 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One-cycle write strobe; the extra edge keeps consecutive calls apart
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    sfr.addr = addr;
    sfr.wdata = data;
    sfr.wr = 1'b1;
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask

  // Read data is registered, so it is sampled one cycle after the strobe
  task automatic rd_chk(input logic [7:0] exp);
    @(negedge mclk);
    sfr.addr = CONTROL_OFFSET;
    sfr.rd = 1'b1;
    @(negedge mclk);
    sfr.rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask

  task automatic do_reset();
    @(negedge mclk);
    reset = 1'b1;
    cyc(4);
    reset = 1'b0;
  endtask

  initial begin
    cyc(4);
    reset = 1'b0;
    // State after reset, oscillator held on against a stop request
    rd_chk(8'h17);
    chk({7'h0, osc_run}, 8'h01);
    chk({7'h0, watchdog_reset}, 8'h00);
    // Second key arriving too late is ignored
    wr(CONTROL_OFFSET, CMD_KEY_FIRST);
    cyc(6);
    wr(CONTROL_OFFSET, CMD_KEY_SECOND);
    cyc(4 * TP);
    rd_chk(8'h17);
    // Interval codes 0 to 6 load; a foreign address is left alone
    for (int n = 0; n < 7; n++) begin
      wr(CONTROL_OFFSET, 8'(n));
      wr(8'h98, 8'h07);
      rd_chk(8'h10 | 8'(n));
      cyc(TP);
    end
    // A frozen block ignores a write
    clk_en = 1'b0;
    wr(CONTROL_OFFSET, 8'h03);
    clk_en = 1'b1;
    rd_chk(8'h16);
    do_reset();
    rd_chk(8'h17);
    // Periodic reloads hold off a limit of 8 ticks
    wr(CONTROL_OFFSET, 8'h01);
    repeat (5) begin
      cyc(4 * TP);
      chk({7'h0, watchdog_reset}, 8'h00);
      wr(CONTROL_OFFSET, CMD_RELOAD);
    end
    cyc(6 * TP);
    chk({7'h0, watchdog_reset}, 8'h00);
    cyc(6 * TP);
    chk({7'h0, watchdog_reset}, 8'h01);
    do_reset();
    // Lock neither reloads nor allows a disable
    wr(CONTROL_OFFSET, 8'h01);
    cyc(5 * TP);
    wr(CONTROL_OFFSET, CMD_LOCK);
    rd_chk(8'h11);
    cyc(5 * TP);
    chk({7'h0, watchdog_reset}, 8'h01);
    wr(CONTROL_OFFSET, CMD_KEY_FIRST);
    wr(CONTROL_OFFSET, CMD_KEY_SECOND);
    cyc(4 * TP);
    rd_chk(8'h11);
    chk({7'h0, osc_run}, 8'h01);
    do_reset();
    // Disable works again after reset, takes three ticks, keeps the count
    cyc(2 * TP);
    wr(CONTROL_OFFSET, CMD_KEY_FIRST);
    wr(CONTROL_OFFSET, CMD_KEY_SECOND);
    cyc(TP);
    rd_chk(8'h17);
    cyc(3 * TP);
    rd_chk(8'h07);
    chk({7'h0, osc_run}, 8'h00);
    osc_stop_req = 1'b0;
    cyc(1);
    chk({7'h0, osc_run}, 8'h01);
    osc_stop_req = 1'b1;
    wr(CONTROL_OFFSET, 8'h01);
    cyc(4 * TP);
    chk({7'h0, watchdog_reset}, 8'h00);
    // Lowering the interval trips the comparator on the held count
    wr(CONTROL_OFFSET, 8'h00);
    cyc(4);
    chk({7'h0, watchdog_reset}, 8'h01);
    // Reload first, then disable and lower the interval: no spurious reset
    do_reset();
    wr(CONTROL_OFFSET, CMD_RELOAD);
    cyc(3 * TP);
    wr(CONTROL_OFFSET, CMD_KEY_FIRST);
    wr(CONTROL_OFFSET, CMD_KEY_SECOND);
    cyc(4 * TP);
    wr(CONTROL_OFFSET, 8'h01);
    cyc(4 * TP);
    chk({7'h0, watchdog_reset}, 8'h00);
    rd_chk(8'h01);
    end_sim();
  end
endmodule // tb_top
